/* File: test/audio_amp_ctrl_regs_6_to_8_tb.sv */
// Self-checking testbench for the control register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
   err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module audio_amp_ctrl_regs_6_to_8_tb;
   import ctrl_regs_pkg::*;
   logic clk, rst_n, is_spi, nonzero_book, addr_msb, v;
   logic rvalid, data_out_pin_oe, incr_en, general_pin_3_sel;
   logic [7:0] page, d, ext_rdata, rdata, next_page, x;
   logic [ADDR_W-1:0] next_addr;
   reg_req_t req;
   ctrl_t ctrl;
   int err_count, checked;
   ctrl_regs ctrl_regs_inst (.*);
   host_model host_model_inst (.*);
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   task rchk(input logic [6:0] a, input logic [7:0] e);
      host_model_inst.rd(a, v, d);
      `CHK("rvalid", 1'b1, v)
      `CHK("rdata", e, d)
   endtask : rchk
   task wrap_up;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   // ==========================================================
   // Scenarios
   task t_filt;
      host_model_inst.wr(OFS_FILT_OUT, 8'h11);
      `CHK("deemph", 1'b1, ctrl.deemphasis_enable)
      rchk(OFS_FILT_OUT, 8'h11);
      host_model_inst.wr(OFS_FILT_OUT, 8'h10);
      `CHK("source", 1'b0, ctrl.serial_out_source_select)
   endtask : t_filt
   task t_pins;
      for (int i = 0; i < 3; i++) begin
         x = 8'h20 >> i;
         host_model_inst.wr(OFS_PIN_DIR, x);
         `CHK("pin2", x[5], ctrl.pin2_output_enable)
         `CHK("mute", x[4], ctrl.amp_silence_control_enable)
         `CHK("pin0", x[3], ctrl.pin0_output_enable)
         rchk(OFS_PIN_DIR, x);
      end
   endtask : t_pins
   task t_func;
      is_spi = 1;
      host_model_inst.wr(OFS_PORT_OPT, 8'h02);
      `CHK("gp3", 1'b1, general_pin_3_sel)
      `CHK("oe", 1'b0, data_out_pin_oe)
      host_model_inst.rd(OFS_FILT_OUT, v, d);
      `CHK("refused", 1'b0, v)
      host_model_inst.wr(OFS_PORT_OPT, 8'h00);
      `CHK("oe", 1'b1, data_out_pin_oe)
   endtask : t_func
   task t_delay;
      host_model_inst.wr(OFS_PORT_OPT, 8'h04);
      rchk(OFS_FILT_OUT, 8'h00);
      rchk(OFS_PIN_DIR, 8'h10);
      host_model_inst.wr(OFS_PORT_OPT, 8'h00);
      rchk(OFS_PIN_DIR, 8'h08);
      nonzero_book = 1;
      rchk(7'h09, 8'h00);
      rchk(7'h09, 8'hA5);
   endtask : t_delay
   task t_wrap;
      is_spi = 0;
      for (int k = 0; k < 2; k++) begin
         nonzero_book = 0;
         host_model_inst.wr(OFS_PORT_OPT, k ? 8'h08 : 8'h00);
         nonzero_book = 1;
         page = 8'h03;
         host_model_inst.place(PAGE_LAST);
         `CHK("naddr", k ? PAGE_FIRST : PAGE_RESTART, next_addr)
         `CHK("npage", k ? 8'h03 : 8'h04, next_page)
         page = 8'h00;
      end
      nonzero_book = 0;
   endtask : t_wrap
   task t_legacy;
      host_model_inst.wr(OFS_PORT_OPT, 8'h00);
      `CHK("inc", 1'b1, incr_en)
      host_model_inst.wr(OFS_PORT_OPT, 8'h10);
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         addr_msb = k[0];
         #1;
         `CHK("inc", k[0], incr_en)
      end
      @(negedge clk);
      is_spi = 1;
      addr_msb = 0;
      #1;
      `CHK("inc spi", 1'b1, incr_en)
   endtask : t_legacy
   initial begin
      rst_n = 0;
      is_spi = 0;
      nonzero_book = 0;
      page = 8'h00;
      addr_msb = 0;
      repeat (20) @(negedge clk);
      rst_n = 1;
      `CHK("ctrl", ctrl_t'(0), ctrl)
      rchk(OFS_PORT_OPT, RST_PORT_OPT);
      t_filt();
      t_pins();
      t_func();
      t_delay();
      t_wrap();
      t_legacy();
      wrap_up();
   end
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end
endmodule : audio_amp_ctrl_regs_6_to_8_tb

/* File: test/ctrl_regs_checker.sv */
// Assertion checker for the control register bank
`timescale 1ns/10ps
module ctrl_regs_checker
   import ctrl_regs_pkg::*;
(
   // Watched ports
   input wire logic clk,
   input wire logic rst_n,
   input wire logic is_spi,
   input wire logic nonzero_book,
   input wire logic addr_msb,
   input wire reg_req_t req,
   input wire logic [7:0] page,
   input wire logic [7:0] next_page,
   input wire logic [ADDR_W-1:0] next_addr,
   input wire logic rvalid,
   input wire logic data_out_pin_oe,
   input wire logic incr_en,
   input wire logic general_pin_3_sel,
   input wire ctrl_t ctrl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic gp3;
   logic wok;
   assign gp3 = ctrl.data_out_pin_function == PIN_FUNC_GENERAL_PIN_3;
   // Writes land only from book 0, page 0
   assign wok = req.wr && !nonzero_book && page == 8'h00;
   // ==========================================================
   // Properties
   a_read_answer: assert property (req.rd && !(is_spi && gp3) |=> rvalid)
      else $error("read not answered");
   a_spi_refuse: assert property (req.rd && is_spi && gp3 |=> !rvalid)
      else $error("spi read answered on general pin");
   a_pin_driver: assert property (data_out_pin_oe ==
      (is_spi && ctrl.data_out_pin_function == PIN_FUNC_SPI_OUT))
      else $error("data out enable wrong");
   a_pin3_select: assert property (general_pin_3_sel == gp3)
      else $error("general pin select wrong");
   a_filter_write: assert property (wok && req.addr == OFS_FILT_OUT |=>
      ctrl.deemphasis_enable == $past(req.wdata[B_DEEMPH]) &&
      ctrl.serial_out_source_select == $past(req.wdata[B_SOURCE_SEL]))
      else $error("filter write lost");
   a_pin_dir_write: assert property (wok && req.addr == OFS_PIN_DIR |=>
      {ctrl.pin2_output_enable, ctrl.amp_silence_control_enable,
      ctrl.pin0_output_enable} == $past(req.wdata[5:3]))
      else $error("pin direction write lost");
   a_page_advance: assert property (nonzero_book && !ctrl.page_wrap_disable
      && req.addr == PAGE_LAST |-> next_addr == PAGE_RESTART &&
      next_page == page + 8'h01) else $error("page advance wrong");
   a_page_hold: assert property (nonzero_book && ctrl.page_wrap_disable &&
      req.addr == PAGE_LAST |-> next_addr == PAGE_FIRST && next_page == page)
      else $error("page wrap wrong");
   a_i2c_increment: assert property (!is_spi |-> incr_en ==
      (ctrl.legacy_increment_mode ? addr_msb : 1'b1))
      else $error("increment mode wrong");
endmodule : ctrl_regs_checker

bind ctrl_regs ctrl_regs_checker ctrl_regs_checker_inst (.*);

/* File: test/host_model.sv */
// Host model: control port accesses launched on the falling edge
`timescale 1ns/10ps
module host_model
   import ctrl_regs_pkg::*;
(
   input wire logic clk,
   input wire logic rvalid,
   input wire logic [DATA_W-1:0] rdata,
   output reg_req_t req,
   output logic [DATA_W-1:0] ext_rdata
);
   initial begin
      req = '0;
      ext_rdata = 8'hA5;
   end
   // Callers keep reserved fields at zero
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic v,
                     output logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
      v = rvalid;
      d = rdata;
   endtask : rd
   // Address only, no strobe, to look at the stepper
   task automatic place(input logic [6:0] a);
      @(negedge clk);
      req.addr = a;
      #1;
   endtask : place
endmodule : host_model

/* File: verilog/addr_stepper.sv */
// Auto-increment next-address and page logic for the control port
`timescale 1ns/10ps
module addr_stepper (
   // Current location
   input wire logic nonzero_book,
   input wire logic [7:0] page,
   input wire logic [ctrl_regs_pkg::ADDR_W-1:0] addr,
   // Mode
   input wire logic page_wrap_disable,
   // Next location
   output logic [7:0] next_page,
   output logic [ctrl_regs_pkg::ADDR_W-1:0] next_addr
);
   import ctrl_regs_pkg::*;

   always_comb begin
      next_page = page;
      next_addr = addr + 7'h01;
      if (addr == PAGE_LAST) begin
         if (nonzero_book && !page_wrap_disable) begin
            next_page = page + 8'h01;
            next_addr = PAGE_RESTART;
         end else begin
            next_addr = PAGE_FIRST;
         end
      end
   end
endmodule : addr_stepper

/* File: verilog/ctrl_regs.sv */
// Control-port options, filter/output select and pin direction registers
`timescale 1ns/10ps
module ctrl_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register access from control port
   input wire ctrl_regs_pkg::reg_req_t req,
   input wire logic is_spi,
   input wire logic nonzero_book,
   input wire logic [7:0] page,
   input wire logic addr_msb,
   input wire logic [ctrl_regs_pkg::DATA_W-1:0] ext_rdata,
   output logic [ctrl_regs_pkg::DATA_W-1:0] rdata,
   output logic rvalid,
   output logic data_out_pin_oe,
   // Auto-increment result
   output logic incr_en,
   output logic [7:0] next_page,
   output logic [ctrl_regs_pkg::ADDR_W-1:0] next_addr,
   // Controls
   output ctrl_regs_pkg::ctrl_t ctrl,
   output logic general_pin_3_sel
);
   import ctrl_regs_pkg::*;

   // ==========================================================
   // Register storage
   logic [DATA_W-1:0] port_opt_r, port_opt_nxt;
   logic [DATA_W-1:0] filt_out_r, filt_out_nxt;
   logic [DATA_W-1:0] pin_dir_r, pin_dir_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic dly_pend_r, dly_pend_nxt;
   logic [DATA_W-1:0] dly_data_r, dly_data_nxt;
   logic [DATA_W-1:0] local_rd;
   logic local_hit;
   logic need_dly;
   logic readout_ok;
   logic rd_taken;
   logic wr_hit;

   function automatic logic [DATA_W-1:0] masked_write(
      input logic [DATA_W-1:0] cur,
      input logic [DATA_W-1:0] wd,
      input logic [DATA_W-1:0] msk
   );
      // Reserved bits stay zero whatever the host writes
      masked_write = (wd & msk) | (cur & ~msk);
   endfunction : masked_write

   // This bank lives only in book 0, page 0; other pages belong elsewhere
   function automatic logic own_page(
      input logic nz_book,
      input logic [7:0] pg
   );
      own_page = !nz_book && (pg == 8'h00);
   endfunction : own_page

   // The three locations of this bank within its page
   function automatic logic in_bank(
      input logic [ADDR_W-1:0] a
   );
      in_bank = (a == OFS_PORT_OPT) || (a == OFS_FILT_OUT)
                || (a == OFS_PIN_DIR);
   endfunction : in_bank

   // Writes elsewhere are for other banks and leave this one untouched
   assign wr_hit = req.wr && own_page(nonzero_book, page);

   always_comb begin
      port_opt_nxt = port_opt_r;
      filt_out_nxt = filt_out_r;
      pin_dir_nxt = pin_dir_r;
      if (wr_hit) begin
         unique case (req.addr)
            OFS_PORT_OPT:
               port_opt_nxt = masked_write(port_opt_r, req.wdata,
                                           MASK_PORT_OPT);
            OFS_FILT_OUT:
               filt_out_nxt = masked_write(filt_out_r, req.wdata,
                                           MASK_FILT_OUT);
            OFS_PIN_DIR:
               pin_dir_nxt = masked_write(pin_dir_r, req.wdata,
                                          MASK_PIN_DIR);
            default: ;
         endcase
      end
   end

   // Synchronous reset: every field comes up cleared
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_opt_r <= RST_PORT_OPT;
         filt_out_r <= RST_FILT_OUT;
         pin_dir_r <= RST_PIN_DIR;
      end else begin
         port_opt_r <= port_opt_nxt;
         filt_out_r <= filt_out_nxt;
         pin_dir_r <= pin_dir_nxt;
      end
   end

   // ==========================================================
   // Decoded controls
   // Controls come straight from the flip-flops, so they never glitch
   always_comb begin
      ctrl.legacy_increment_mode = port_opt_r[B_LEGACY_INC];
      ctrl.page_wrap_disable = port_opt_r[B_PAGE_WRAP_DIS];
      ctrl.read_frame_delay = port_opt_r[B_READ_FRAME_DLY];
      // Only the low code bit is stored, so the reserved codes can never
      // appear even if the host ignores the do-not-set rule
      ctrl.data_out_pin_function = {1'b0, port_opt_r[B_PIN_FUNC]};
      ctrl.deemphasis_enable = filt_out_r[B_DEEMPH];
      ctrl.serial_out_source_select = filt_out_r[B_SOURCE_SEL];
      ctrl.pin2_output_enable = pin_dir_r[B_PIN2_OE];
      ctrl.amp_silence_control_enable = pin_dir_r[B_SILENCE_EN];
      ctrl.pin0_output_enable = pin_dir_r[B_PIN0_OE];
   end

   assign general_pin_3_sel =
      (ctrl.data_out_pin_function == PIN_FUNC_GENERAL_PIN_3);
   assign readout_ok =
      (ctrl.data_out_pin_function == PIN_FUNC_SPI_OUT);

   // ==========================================================
   // Auto-increment
   // I2C increments unless legacy mode is set and the address MSB is clear
   // SPI always increments; the legacy choice only concerns I2C
   assign incr_en = is_spi || !ctrl.legacy_increment_mode
                    || addr_msb;

   // Next location is offered every cycle; the port decides when to use it
   addr_stepper u_step (
      .nonzero_book(nonzero_book),
      .page(page),
      .addr(req.addr),
      .page_wrap_disable(ctrl.page_wrap_disable),
      .next_page(next_page),
      .next_addr(next_addr)
   );

   // ==========================================================
   // Read path with optional one-frame delay
   // Only this bank's three locations answer from local storage
   assign local_hit = own_page(nonzero_book, page) && in_bank(req.addr);

   always_comb begin
      local_rd = ext_rdata;
      if (local_hit) begin
         unique case (req.addr)
            OFS_PORT_OPT: local_rd = port_opt_r;
            OFS_FILT_OUT: local_rd = filt_out_r;
            OFS_PIN_DIR: local_rd = pin_dir_r;
            default: local_rd = ext_rdata;
         endcase
      end
   end

   // The frame delay is kept as a one-read pipeline: each delayed read
   // returns what the previous delayed read addressed. The first one after
   // a direct read returns zero, so the host spends one dummy read there.
   assign need_dly = is_spi && (nonzero_book
                     || ctrl.read_frame_delay);

   // An SPI readout while the pin serves as general pin 3 would have no wire,
   // so the read is dropped and rdata keeps its last value
   assign rd_taken = req.rd && !(is_spi && !readout_ok);

   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      dly_pend_nxt = dly_pend_r;
      dly_data_nxt = dly_data_r;
      if (rd_taken) begin
         rvalid_nxt = 1'b1;
         if (need_dly) begin
            // Frame n returns data captured at frame n-1
            rdata_nxt = dly_pend_r ? dly_data_r : 8'h00;
            dly_data_nxt = local_rd;
            dly_pend_nxt = 1'b1;
         end else begin
            rdata_nxt = local_rd;
            dly_pend_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
         dly_pend_r <= 1'b0;
         dly_data_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         dly_pend_r <= dly_pend_nxt;
         dly_data_r <= dly_data_nxt;
      end
   end

   // rdata holds until the next accepted read; rvalid pulses once
   assign rdata = rdata_r;
   assign rvalid = rvalid_r;
   // The pin drives only in SPI mode with its SPI function; as general
   // pin 3 its direction is left to the pin logic outside this bank
   assign data_out_pin_oe = is_spi && readout_ok;
endmodule : ctrl_regs

/* File: verilog/ctrl_regs_pkg.sv */
// Package: offsets, field positions, reset values and carriers for regs 6-8
package ctrl_regs_pkg;
   // ==========================================================
   // Register offsets and widths
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam logic [ADDR_W-1:0] OFS_PORT_OPT = 7'h06;
   localparam logic [ADDR_W-1:0] OFS_FILT_OUT = 7'h07;
   localparam logic [ADDR_W-1:0] OFS_PIN_DIR = 7'h08;
   localparam logic [ADDR_W-1:0] PAGE_LAST = 7'h7F;
   localparam logic [ADDR_W-1:0] PAGE_RESTART = 7'h08;
   localparam logic [ADDR_W-1:0] PAGE_FIRST = 7'h00;
   // ==========================================================
   // Field positions
   localparam int unsigned B_LEGACY_INC = 4;
   localparam int unsigned B_PAGE_WRAP_DIS = 3;
   localparam int unsigned B_READ_FRAME_DLY = 2;
   localparam int unsigned B_PIN_FUNC = 1;
   localparam int unsigned B_DEEMPH = 4;
   localparam int unsigned B_SOURCE_SEL = 0;
   localparam int unsigned B_PIN2_OE = 5;
   localparam int unsigned B_SILENCE_EN = 4;
   localparam int unsigned B_PIN0_OE = 3;
   // ==========================================================
   // Writable masks and reset values
   localparam logic [DATA_W-1:0] MASK_PORT_OPT = 8'h1E;
   localparam logic [DATA_W-1:0] MASK_FILT_OUT = 8'h11;
   localparam logic [DATA_W-1:0] MASK_PIN_DIR = 8'h38;
   localparam logic [DATA_W-1:0] RST_PORT_OPT = 8'h00;
   localparam logic [DATA_W-1:0] RST_FILT_OUT = 8'h00;
   localparam logic [DATA_W-1:0] RST_PIN_DIR = 8'h00;
   localparam int unsigned FRAME_DLY_FRAMES = 1;
   // Data-out pin function codes
   localparam logic [1:0] PIN_FUNC_SPI_OUT = 2'h0;
   localparam logic [1:0] PIN_FUNC_GENERAL_PIN_3 = 2'h1;

   // Control port access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   // Decoded control outputs
   typedef struct packed {
      logic legacy_increment_mode;
      logic page_wrap_disable;
      logic read_frame_delay;
      logic [1:0] data_out_pin_function;
      logic deemphasis_enable;
      logic serial_out_source_select;
      logic pin2_output_enable;
      logic amp_silence_control_enable;
      logic pin0_output_enable;
   } ctrl_t;
endpackage : ctrl_regs_pkg
